// File: seg_desc_map.svh
`ifndef SEG_DESC_MAP_SVH
`define SEG_DESC_MAP_SVH

// Register byte offsets
`define OFS_GLOBAL_BASE 8'h00
`define OFS_LOCAL_BASE  8'h04
`define OFS_LOAD        8'h08
`define OFS_SEL_FIRST   8'h10
`define OFS_SEL_LAST    8'h24

// Reset values
`define RST_TABLE_BASE  32'h0000_0000
`define RST_SELECTOR    16'h0000

// Load command fields
`define CMD_SEL_MSB     15
`define CMD_SEG_LSB     16
`define CMD_SEG_MSB     18
`define CMD_GATE        3'h7

// Segment register slots
`define SEG_COUNT       3'h6
`define SEG_SLOTS       8
`define SEG_STACK       3'h2

// Status fields
`define STAT_BUSY       0
`define STAT_FAULT      1
`define STAT_VEC_LSB    8

// Fault vector for a gate that is not present
`define NP_VECTOR       8'h0b

// Descriptor fetch step, one 32-bit word
`define WORD_STEP       32'h0000_0004

`endif

// File: seg_desc_pkg.sv
package seg_desc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LO   = 2'b01,
    ST_HI   = 2'b11,
    ST_WR   = 2'b10
  } state_t;

  typedef enum logic [2:0] {
    GK_NONE = 3'h0,
    GK_CALL = 3'h1,
    GK_TASK = 3'h2,
    GK_INTR = 3'h3,
    GK_TRAP = 3'h4
  } gate_kind_t;

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] limit;
    logic [3:0]  kind;
    logic        sys;
    logic [1:0]  descriptor_privilege;
    logic        present;
    logic        legacy;
    logic        big;
    logic        type_bad;
  } desc_t;

  typedef struct packed {
    gate_kind_t  kind;
    logic [15:0] target_sel;
    logic [31:0] target_ofs;
    logic [4:0]  param_count;
    logic        param32;
    logic        push32;
    logic        clear_if;
  } gate_t;

  // Legacy descriptors have no codes with the top type bit set
  function automatic logic type_ok(input logic [3:0] t,
                                   input logic legacy);
    type_ok = !(legacy && t[3]);
  endfunction : type_ok

  function automatic gate_kind_t gate_kind(input logic [3:0] t,
                                           input logic legacy);
    gate_kind = GK_NONE;
    if (type_ok(t, legacy)) begin
      case (t)
        4'h4, 4'hc: gate_kind = GK_CALL;
        4'h5:       gate_kind = GK_TASK;
        4'h6, 4'he: gate_kind = GK_INTR;
        4'h7, 4'hf: gate_kind = GK_TRAP;
        default:    gate_kind = GK_NONE;
      endcase
    end
  endfunction : gate_kind

endpackage : seg_desc_pkg

// File: desc_decode.sv
`timescale 1ns/100ps
`default_nettype none

module desc_decode
  import seg_desc_pkg::*;
(
  // Descriptor words
  input  wire logic [31:0] lo_i,
  input  wire logic [31:0] hi_i,
  // Decoded views
  output var  desc_t       desc_o,
  output var  gate_t       gate_o
);

  logic legacy;

  always_comb begin
    legacy = (hi_i[31:16] == 16'h0000); // R4
    desc_o.legacy = legacy;
    desc_o.kind = hi_i[11:8];
    // Set for system descriptors, whose S bit is clear
    desc_o.sys = !hi_i[12]; // R15
    desc_o.descriptor_privilege = hi_i[14:13];
    desc_o.present = hi_i[15];
    desc_o.big = hi_i[22];
    desc_o.type_bad = !hi_i[12] && !type_ok(hi_i[11:8], legacy); // R15
    if (legacy) begin
      desc_o.base = {8'h00, hi_i[7:0], lo_i[31:16]}; // R2
      desc_o.limit = {16'h0000, lo_i[15:0]}; // R2
    end else begin
      desc_o.base = {hi_i[31:24], hi_i[7:0], lo_i[31:16]}; // R3
      if (hi_i[23]) begin
        desc_o.limit = {hi_i[19:16], lo_i[15:0], 12'hfff}; // R3
      end else begin
        desc_o.limit = {12'h000, hi_i[19:16], lo_i[15:0]}; // R3
      end
    end
    // Code and data descriptors are never gates
    gate_o.kind = hi_i[12] ? GK_NONE : gate_kind(hi_i[11:8], legacy); // R7
    gate_o.target_sel = lo_i[31:16];
    gate_o.target_ofs = legacy ? {16'h0000, lo_i[15:0]}
                               : {hi_i[31:16], lo_i[15:0]};
    gate_o.param_count = hi_i[4:0]; // R5
    gate_o.param32 = (gate_o.kind == GK_CALL) && !legacy; // R5
    gate_o.push32 = 1'b0;
    gate_o.clear_if = (gate_o.kind == GK_INTR); // R16
  end

endmodule : desc_decode

`default_nettype wire

// File: desc_cache_mem.sv
`timescale 1ns/100ps
`default_nettype none
`include "seg_desc_map.svh"

module desc_cache_mem
  import seg_desc_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // Write port
  input  wire logic       we_i,
  input  wire logic [2:0] waddr_i,
  input  wire desc_t      wdata_i,
  // Read port
  input  wire logic [2:0] raddr_i,
  output var  desc_t      rdata_o
);

  desc_t mem [`SEG_SLOTS];
  desc_t next_rdata;

  for (genvar i = 0; i < `SEG_SLOTS; i++) begin : g_entry
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        mem[i] <= '0;
      end else if (we_i && (waddr_i == 3'(i))) begin
        mem[i] <= wdata_i; // R13
      end
    end
  end

  always_comb begin
    next_rdata = mem[raddr_i]; // R12
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule : desc_cache_mem

`default_nettype wire

// File: seg_desc_cache.sv
`timescale 1ns/100ps
`default_nettype none
`include "seg_desc_map.svh"

// How it works
// R1: Accept both legacy and native descriptor formats.
// R2: Legacy descriptor: 24-bit base, 16-bit limit.
// R3: Native: 32-bit base, 20-bit limit, granularity scaling.
// R4: Upper word zero means legacy, else native.
// R5: Gate count: 16-bit legacy, 32-bit native items.
// R6: Stack width flag sets push size 16/32.
// R7: Decode gate type codes 4-7 and C, E, F.
// R8: Selector splits into table, index, privilege.
// R9: Index picks one of 8K table entries.
// R10: Requested privilege bits exported without descriptor fetch.
// R11: Per-register cache, loaded on every selector write.
// R12: References use cache, never refetch descriptors.
// R13: Cache changes only on segment register reload.
// R14: Only selectors readable, cache contents hidden.
// R15: Type field interpreted according to descriptor format.
// R16: Interrupt gate clears interrupt flag, trap keeps.
// R17: Absent gate raises not-present fault, vector 11.
// R18: Fetch at table base plus 8*index, two words.
module seg_desc_cache
  import seg_desc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Descriptor table fetch
  output logic             mem_req_o,
  output logic      [31:0] mem_addr_o,
  input  wire logic [31:0] mem_rdata_i,
  input  wire logic        mem_ack_i,
  // Segment references
  input  wire logic [2:0]  ref_seg_i,
  output var  desc_t       ref_desc_o,
  output logic      [1:0]  ref_priv_o,
  // Gate results
  output var  gate_t       gate_o,
  output logic             gate_valid_o,
  output logic             fault_o,
  output logic      [7:0]  fault_vec_o,
  output logic             load_done_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Table base plus eight bytes per entry
  function automatic logic [31:0] fetch_addr(input logic [15:0] sel,
                                             input logic [31:0] gb,
                                             input logic [31:0] lb);
    logic [31:0] tbase;
    tbase = sel[2] ? lb : gb; // R8
    fetch_addr = tbase + {16'h0000, sel[15:3], 3'b000}; // R9
  endfunction : fetch_addr

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) &&
             ((a <= `OFS_LOAD) ||
              ((a >= `OFS_SEL_FIRST) && (a <= `OFS_SEL_LAST)));
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // State

  state_t      state;
  state_t      next_state;
  logic [31:0] gbase;
  logic [31:0] next_gbase;
  logic [31:0] lbase;
  logic [31:0] next_lbase;
  logic [2:0]  cmd_seg;
  logic [2:0]  next_cmd_seg;
  logic [15:0] cmd_sel;
  logic [15:0] next_cmd_sel;
  logic [31:0] lo_word;
  logic [31:0] next_lo_word;
  logic [31:0] hi_word;
  logic [31:0] next_hi_word;
  logic [15:0] sel_q    [`SEG_SLOTS];
  logic [15:0] next_sel [`SEG_SLOTS];
  logic        ss_big;
  logic        next_ss_big;
  logic        fault_seen;
  logic        next_fault_seen;
  logic        next_mem_req;
  logic [31:0] next_mem_addr;
  gate_t       next_gate;
  logic        next_gate_valid;
  logic        next_fault;
  logic [7:0]  next_fault_vec;
  logic        next_done;
  logic [1:0]  next_priv;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  desc_t       dec_desc;
  gate_t       dec_gate;
  logic        cache_we;
  logic        access;
  logic        commit;
  logic        start;
  logic        cmd_gate;
  logic        busy;
  logic [2:0]  slot;

  assign access   = psel_i && penable_i && !pready_o;
  assign commit   = psel_i && penable_i && pready_o && !pslverr_o;
  assign start    = commit && pwrite_i && (paddr_i == `OFS_LOAD);
  assign cmd_gate = (cmd_seg == `CMD_GATE);
  assign busy     = (state != ST_IDLE);
  assign slot     = 3'(paddr_i[7:2] - 6'(`OFS_SEL_FIRST >> 2));

  ////////////////////////////////////////////////////////////////////////////
  // Decode and cache storage

  // One decoder serves both formats, picked per descriptor
  desc_decode u_decode ( // R1
    .lo_i   (lo_word),
    .hi_i   (hi_word),
    .desc_o (dec_desc),
    .gate_o (dec_gate)
  );

  // Read data is registered, so a reference sees its slot a cycle later
  desc_cache_mem u_cache (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .we_i      (cache_we),
    .waddr_i   (cmd_seg),
    .wdata_i   (dec_desc),
    .raddr_i   (ref_seg_i),
    .rdata_o   (ref_desc_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Load sequencer

  always_comb begin
    next_state      = state;
    next_cmd_seg    = cmd_seg;
    next_cmd_sel    = cmd_sel;
    next_lo_word    = lo_word;
    next_hi_word    = hi_word;
    next_sel        = sel_q;
    next_ss_big     = ss_big;
    next_fault_seen = fault_seen;
    next_mem_req    = mem_req_o;
    next_mem_addr   = mem_addr_o;
    next_gate       = gate_o;
    next_gate_valid = 1'b0;
    next_fault      = 1'b0;
    next_fault_vec  = fault_vec_o;
    next_done       = 1'b0;
    cache_we        = 1'b0;
    next_priv       = sel_q[ref_seg_i][1:0]; // R10
    unique case (state)
      ST_IDLE: begin
        if (start) begin
          next_cmd_seg    = pwdata_i[`CMD_SEG_MSB:`CMD_SEG_LSB];
          next_cmd_sel    = pwdata_i[`CMD_SEL_MSB:0];
          next_mem_req    = 1'b1;
          next_mem_addr   = fetch_addr(pwdata_i[`CMD_SEL_MSB:0],
                                       gbase, lbase); // R18
          next_fault_seen = 1'b0;
          next_state      = ST_LO;
        end
      end
      ST_LO: begin
        if (mem_ack_i) begin
          next_lo_word  = mem_rdata_i;
          next_mem_addr = mem_addr_o + `WORD_STEP; // R18
          next_state    = ST_HI;
        end
      end
      ST_HI: begin
        if (mem_ack_i) begin
          next_hi_word = mem_rdata_i;
          next_mem_req = 1'b0;
          next_state   = ST_WR;
        end
      end
      ST_WR: begin
        next_done  = 1'b1;
        next_state = ST_IDLE;
        if (cmd_gate) begin
          if (!dec_desc.present) begin
            next_fault      = 1'b1; // R17
            next_fault_vec  = `NP_VECTOR; // R17
            next_fault_seen = 1'b1;
          end else begin
            next_gate        = dec_gate;
            // Push size follows the cached stack segment width
            next_gate.push32 = ss_big; // R6
            next_gate_valid  = 1'b1;
          end
        end else begin
          cache_we          = 1'b1; // R11
          next_sel[cmd_seg] = cmd_sel; // R11
          if (cmd_seg == `SEG_STACK) begin
            next_ss_big = dec_desc.big; // R6
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state        <= ST_IDLE;
      cmd_seg      <= 3'h0;
      cmd_sel      <= `RST_SELECTOR;
      lo_word      <= 32'h0000_0000;
      hi_word      <= 32'h0000_0000;
      sel_q        <= '{default: `RST_SELECTOR};
      ss_big       <= 1'b0;
      fault_seen   <= 1'b0;
      mem_req_o    <= 1'b0;
      mem_addr_o   <= 32'h0000_0000;
      gate_o       <= '0;
      gate_valid_o <= 1'b0;
      fault_o      <= 1'b0;
      fault_vec_o  <= 8'h00;
      load_done_o  <= 1'b0;
      ref_priv_o   <= 2'h0;
    end else begin
      state        <= next_state;
      cmd_seg      <= next_cmd_seg;
      cmd_sel      <= next_cmd_sel;
      lo_word      <= next_lo_word;
      hi_word      <= next_hi_word;
      sel_q        <= next_sel;
      ss_big       <= next_ss_big;
      fault_seen   <= next_fault_seen;
      mem_req_o    <= next_mem_req;
      mem_addr_o   <= next_mem_addr;
      gate_o       <= next_gate;
      gate_valid_o <= next_gate_valid;
      fault_o      <= next_fault;
      fault_vec_o  <= next_fault_vec;
      load_done_o  <= next_done;
      ref_priv_o   <= next_priv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state

  always_comb begin
    next_gbase   = gbase;
    next_lbase   = lbase;
    next_pready  = access;
    next_prdata  = prdata_o;
    next_pslverr = pslverr_o;
    if (access) begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = !mapped(paddr_i);
      if (pwrite_i && (paddr_i == `OFS_LOAD)) begin
        // A second load while one runs would corrupt the fetch
        next_pslverr = busy ||
          (pwdata_i[`CMD_SEG_MSB:`CMD_SEG_LSB] == `SEG_COUNT);
      end
      if (!pwrite_i && mapped(paddr_i)) begin
        if (paddr_i == `OFS_GLOBAL_BASE) begin
          next_prdata = gbase;
        end else if (paddr_i == `OFS_LOCAL_BASE) begin
          next_prdata = lbase;
        end else if (paddr_i == `OFS_LOAD) begin
          next_prdata[`STAT_BUSY]  = busy;
          next_prdata[`STAT_FAULT] = fault_seen;
          next_prdata[`STAT_VEC_LSB +: 8] = fault_vec_o;
        end else begin
          next_prdata = {16'h0000, sel_q[slot]}; // R14
        end
      end
    end
    if (commit && pwrite_i) begin
      if (paddr_i == `OFS_GLOBAL_BASE) begin
        next_gbase = pwdata_i;
      end
      if (paddr_i == `OFS_LOCAL_BASE) begin
        next_lbase = pwdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gbase     <= `RST_TABLE_BASE;
      lbase     <= `RST_TABLE_BASE;
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      gbase     <= next_gbase;
      lbase     <= next_lbase;
      pready_o  <= next_pready;
      prdata_o  <= next_prdata;
      pslverr_o <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_lo_taken;
    (state == ST_LO) && mem_ack_i;
  endsequence

  sequence s_hi_taken;
    (state == ST_HI) && mem_ack_i;
  endsequence

  a_fetch_first_addr: assert property ( // R18
    start |=> mem_req_o && (state == ST_LO) &&
      (mem_addr_o == fetch_addr(cmd_sel, gbase, lbase)))
    else $error("first descriptor word address wrong");

  a_fetch_next_word: assert property ( // R18
    s_lo_taken |=> (state == ST_HI) &&
      (mem_addr_o == $past(mem_addr_o) + `WORD_STEP))
    else $error("second descriptor word address wrong");

  // The far side leaves at least one idle cycle between the two words
  a_load_two_words: assert property ( // R11
    s_hi_taken |=> (state == ST_WR) && !mem_req_o ##1
      ((state == ST_IDLE) && load_done_o && !mem_req_o))
    else $error("load did not end after two words");

  a_fetch_only_load: assert property ( // R12
    mem_req_o |-> (state == ST_LO) || (state == ST_HI))
    else $error("descriptor fetch outside a load");

  a_cache_on_reload: assert property ( // R13
    cache_we |-> (state == ST_WR) && !cmd_gate)
    else $error("cache written outside a reload");

  a_sel_updated: assert property ( // R11
    (state == ST_WR) && !cmd_gate |=>
      (sel_q[$past(cmd_seg)] == $past(cmd_sel)))
    else $error("selector not stored on load");

  a_legacy_class: assert property ( // R4
    (state == ST_WR) |->
      (dec_desc.legacy == (hi_word[31:16] == 16'h0000)))
    else $error("descriptor format misclassified");

  a_legacy_width: assert property ( // R2
    (state == ST_WR) && dec_desc.legacy |->
      (dec_desc.base[31:24] == 8'h00) &&
      (dec_desc.limit[31:16] == 16'h0000))
    else $error("legacy base or limit too wide");

  a_native_gran: assert property ( // R3
    (state == ST_WR) && !dec_desc.legacy && hi_word[23] |->
      (dec_desc.limit == {hi_word[19:16], lo_word[15:0], 12'hfff}))
    else $error("granular limit not scaled");

  a_gate_absent: assert property ( // R17
    (state == ST_WR) && cmd_gate && !dec_desc.present |=>
      fault_o && !gate_valid_o && (fault_vec_o == `NP_VECTOR))
    else $error("absent gate did not fault");

  a_gate_if_flag: assert property ( // R16
    gate_valid_o |->
      (gate_o.clear_if == (gate_o.kind == GK_INTR)))
    else $error("interrupt flag handling wrong");

  a_priv_direct: assert property ( // R10
    (state == ST_WR) && !cmd_gate && (ref_seg_i == cmd_seg) ##1
      (ref_seg_i == $past(ref_seg_i)) |=>
      (ref_priv_o == $past(cmd_sel[1:0], 2)))
    else $error("requested privilege not exported");

endmodule : seg_desc_cache

`default_nettype wire

// File: desc_table_model.sv
`timescale 1ns/100ps
`default_nettype none

// Descriptor tables in system memory, answering one word per ack pulse
module desc_table_model (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // Fetch link
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [3:0]  delay_i,
  output logic      [31:0] rdata_o,
  output logic             ack_o,
  // Observation
  output int               fetches_o,
  output logic      [31:0] first_o
);
  logic [31:0] words [logic [31:0]];
  logic [3:0]  waited;
  logic        req_q;

  ////////////////////////////////////////////////////////////////////////////
  // Idle data toggles so that a word taken without an ack never matches
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_o     <= 1'b0;
      rdata_o   <= 32'h5a5a_a5a5;
      waited    <= 4'h0;
      req_q     <= 1'b0;
      fetches_o <= 0;
      first_o   <= 32'h0;
    end else begin
      req_q <= req_i;
      if (req_i && !req_q) begin
        fetches_o <= fetches_o + 1;
        first_o   <= addr_i;
      end
      if (ack_o || !req_i || waited < delay_i) begin
        ack_o   <= 1'b0;
        rdata_o <= ~rdata_o;
        waited  <= (ack_o || !req_i) ? 4'h0 : waited + 4'h1;
      end else begin
        ack_o   <= 1'b1;
        rdata_o <= words.exists(addr_i) ? words[addr_i] : 32'h0;
      end
    end
  end
endmodule : desc_table_model

`default_nettype wire

// File: segment_descriptor_decode_cache_tb.sv
`timescale 1ns/100ps
`default_nettype none

module segment_descriptor_decode_cache_tb;
  import seg_desc_pkg::*;

  logic        mclk_i, sys_rst_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i, fault_vec_o;
  logic [31:0] pwdata_i, prdata_o, mem_addr_o, mem_rdata_i;
  logic        pready_o, pslverr_o, mem_req_o, mem_ack_i;
  logic [2:0]  ref_seg_i, s;
  desc_t       ref_desc_o;
  logic [1:0]  ref_priv_o;
  gate_t       gate_o;
  logic        gate_valid_o, fault_o, load_done_o, er, gv, ft;
  logic [3:0]  delay, t;
  int          fetches, fails, check_count, cycles = 0;
  logic [31:0] first, seed, rd, gb, lb, lo, hi, ofs;
  logic [15:0] sel;
  desc_t       ec [6];
  logic [15:0] es [6];
  logic [3:0]  gt [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'he, 4'hf, 4'h6};

  seg_desc_cache DUT (.mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mem_req_o,
    .mem_addr_o, .mem_rdata_i, .mem_ack_i, .ref_seg_i, .ref_desc_o,
    .ref_priv_o, .gate_o, .gate_valid_o, .fault_o, .fault_vec_o,
    .load_done_o);
  desc_table_model mem (.mclk_i, .sys_rst_i, .req_i(mem_req_o),
    .addr_i(mem_addr_o), .delay_i(delay), .rdata_o(mem_rdata_i),
    .ack_o(mem_ack_i), .fetches_o(fetches), .first_o(first));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] addr_of(input logic [15:0] v);
    return (v[2] ? lb : gb) + {16'h0, v[15:3], 3'h0};
  endfunction : addr_of

  function automatic desc_t exp_desc(input logic [31:0] l, h);
    desc_t e;
    e = '0;
    e.legacy = (h[31:16] == 16'h0);
    e.base = {e.legacy ? 8'h00 : h[31:24], h[7:0], l[31:16]};
    e.limit = {12'h0, h[19:16], l[15:0]};
    if (!e.legacy && h[23]) e.limit = {e.limit[19:0], 12'hfff};
    e.kind = h[11:8];
    e.sys = !h[12];
    e.descriptor_privilege = h[14:13];
    e.present = h[15];
    e.big = h[22];
    e.type_bad = e.legacy && !h[12] && h[11];
    return e;
  endfunction : exp_desc

  // Every field that a reference shows, in one word
  function automatic logic [74:0] vis(input desc_t d);
    return {d.base, d.limit, d.kind, d.sys, d.descriptor_privilege,
            d.present, d.legacy, d.big, d.type_bad};
  endfunction : vis

  function automatic gate_t exp_gate(input logic [31:0] l, h,
                                     input logic big);
    gate_t g;
    g = '0;
    case (h[11:8])
      4'h4, 4'hc: g.kind = GK_CALL;
      4'h5:       g.kind = GK_TASK;
      4'h6, 4'he: g.kind = GK_INTR;
      4'h7, 4'hf: g.kind = GK_TRAP;
      default:    g.kind = GK_NONE;
    endcase
    g.target_sel = l[31:16];
    g.target_ofs = {h[31:16], l[15:0]};
    g.param_count = h[4:0];
    g.param32 = (h[31:16] != 16'h0) && g.kind == GK_CALL;
    g.push32 = big;
    g.clear_if = g.kind == GK_INTR;
    return g;
  endfunction : exp_gate

  // Fields that a gate kind ignores are hidden on both sides
  function automatic gate_t gmask(input gate_t g, input gate_kind_t k);
    if (k != GK_CALL) {g.param_count, g.param32, g.push32} = '0;
    if (k == GK_TASK) g.target_ofs = '0;
    return g;
  endfunction : gmask

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [127:0] e, g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", w, e, g);
    end
  endtask : check

  task automatic stop_test();
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    // No cycle limit here: pready_o ends this wait, or else the bench timeout
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic put(input logic [15:0] v, input logic [31:0] l, h);
    mem.words[addr_of(v)] = l;
    mem.words[addr_of(v) + 32'h4] = h;
  endtask : put

  task automatic wait_done(input logic [15:0] v);
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (load_done_o !== 1'b1 && n < 100);
    gv = gate_valid_o;
    ft = fault_o;
    check("load_done", 1'b1, load_done_o);
    check("fetch_addr", addr_of(v), first);
  endtask : wait_done

  task automatic load(input logic [2:0] g, input logic [15:0] v);
    apb(1'b1, 8'h08, {13'h0, g, v});
    check("load_err", 1'b0, er);
    wait_done(v);
  endtask : load

  task automatic look(input logic [2:0] g);
    int n;
    n = fetches;
    @(posedge mclk_i);
    ref_seg_i <= g;
    repeat (2) @(posedge mclk_i);
    #1;
    check("ref_desc", vis(ec[g]), vis(ref_desc_o));
    check("ref_priv", es[g][1:0], ref_priv_o);
    check("fetches", n, fetches);
  endtask : look

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    sys_rst_i = 1'b1;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    ref_seg_i = 3'h0;
    delay = 4'h0;
    seed = 32'h1bba6933;
    fails = 0;
    check_count = 0;
    for (int i = 0; i < 6; i++) begin
      ec[i] = '0;
      es[i] = 16'h0;
    end
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, (i < 2) ? 8'(4 * i) : (i == 8) ? 8'h0c : 8'(8 + 4 * i), 0);
      check("reset_read", {i == 8, 32'h0}, {er, rd});
    end
    gb = rnd() & 32'hffff_fff8;
    lb = rnd() & 32'hffff_fff8;
    apb(1'b1, 8'h00, gb);
    apb(1'b1, 8'h04, lb);
    apb(1'b1, 8'h14, 32'hffff);
    apb(1'b0, 8'h14, 0);
    check("ro_selector", 33'h0, {er, rd});
    apb(1'b0, 8'h04, 0);
    check("local_base", lb, rd);
    for (int i = 0; i < 16; i++) begin
      s = 3'(rnd() % 6);
      sel = 16'(rnd());
      if (i == 0) sel[15:3] = 13'h1fff;
      lo = rnd();
      hi = rnd();
      if (rnd() & 1) hi[31:16] = 16'h0;
      if (i == 1) hi[23] = 1'b1;
      delay = 4'(rnd() & 3);
      put(sel, lo, hi);
      load(s, sel);
      ec[s] = exp_desc(lo, hi);
      es[s] = sel;
      look(s);
      apb(1'b0, 8'h10 + 8'(4 * s), 0);
      check("selector", {16'h0, sel}, rd);
    end
    put(sel, ~lo, ~hi);
    look(s);
    load(s, sel);
    ec[s] = exp_desc(~lo, ~hi);
    look(s);
    delay = 4'h6;
    put(16'h0, 32'h1234_5678, 32'h00cf_9a00);
    apb(1'b1, 8'h08, 32'h0001_0000);
    apb(1'b1, 8'h08, 32'h0003_0000);
    check("busy_refused", 1'b1, er);
    wait_done(16'h0);
    ec[1] = exp_desc(32'h1234_5678, 32'h00cf_9a00);
    es[1] = 16'h0;
    apb(1'b1, 8'h08, 32'h0006_0000);
    check("seg6_refused", 1'b1, er);
    for (int b = 0; b < 2; b++) begin
      delay = 4'(rnd() & 3);
      hi = 32'h0100_9200 | (b << 22);
      put(16'h0008, 32'h0000_ffff, hi);
      load(3'h2, 16'h0008);
      ec[2] = exp_desc(32'h0000_ffff, hi);
      es[2] = 16'h0008;
      for (int k = 0; k < 8; k++) begin
        t = gt[k];
        ofs = rnd();
        if (!t[3]) ofs[31:16] = 16'h0;
        else ofs[16] = 1'b1;
        lo = {16'(rnd()), ofs[15:0]};
        hi = {ofs[31:16], k != 7, 2'(k), 1'b0, t, 3'h0, 5'(rnd())};
        put(16'h0010, lo, hi);
        load(3'h7, 16'h0010);
        if (k == 7) begin
          check("fault", 2'b10, {ft, gv});
          check("fault_vec", 8'h0b, fault_vec_o);
          apb(1'b0, 8'h08, 0);
          check("status", {8'h0b, 2'b10}, {rd[15:8], rd[1:0]});
        end else begin
          check("gate_valid", 2'b01, {ft, gv});
          check("gate", gmask(exp_gate(lo, hi, b[0]), gate_o.kind),
                gmask(gate_o, gate_o.kind));
        end
      end
    end
    for (int i = 0; i < 6; i++) look(3'(i));
    stop_test();
  end
endmodule : segment_descriptor_decode_cache_tb

`default_nettype wire
